// *** ppgc_defines.svh ***
// register offsets, field positions, function code, reset and underflow values
`ifndef PPGC_DEFINES_SVH
`define PPGC_DEFINES_SVH
`define PPGC_OFS_CTRL      12'h000
`define PPGC_OFS_STAT      12'h004
`define PPGC_OFS_LOW       12'h008
`define PPGC_OFS_HIGH      12'h00C
`define PPGC_OFS_COUNT     12'h010
`define PPGC_CT_SOFTWARE_TRIGGER       0
`define PPGC_CT_COUNT_ENABLE       1
`define PPGC_CT_ONE_SHOT_SELECT       2
`define PPGC_CT_POL        3
`define PPGC_CT_FMD_LO     4
`define PPGC_CT_CKS_LO     12
`define PPGC_CT_EGS_LO     8
`define PPGC_CT2_COUNT_CLOCK_SELECT_MSB      8
`define PPGC_ST_UDF        0
`define PPGC_ST_TRG        2
`define PPGC_ST_UNDERFLOW_IRQ_ENABLE       4
`define PPGC_ST_TRIGGER_IRQ_ENABLE       6
`define PPGC_FMD_PPG       3'h2
`define PPGC_RST_WORD      16'h0000
`define PPGC_UNDERFLOW     16'h0000
`endif

// *** ppgc_pkg.sv ***
// shared types of the pulse generator control block
package ppgc_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} ppgc_phase_t;
  typedef struct packed {
    logic [2:0] function_select;
    logic       output_polarity;
    logic       one_shot_select;
    logic       count_enable;
    logic [2:0] clk_sel_lo;
    logic [1:0] edge_sel;
    logic       count_clock_select_msb;
  } ppgc_ctrl_t;
  typedef struct packed {
    ppgc_ctrl_t  ctrl;
    logic        trigger_irq_enable;
    logic        underflow_irq_enable;
    logic        trigger_flag;
    logic        underflow_flag;
    logic [15:0] low_width_reload;
    logic [15:0] high_width_reload;
    logic [15:0] high_width_buffer;
    logic [15:0] counter_value;
    ppgc_phase_t phase;
    logic [10:0] presc;
    logic [2:0]  trg_sync;
    logic        out_lvl;
    logic        pin;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
  } ppgc_state_t;
endpackage

// *** ppgc_top.sv ***
// programmable pulse generator mode of a 16-bit base timer, APB slave
`timescale 1ns/1ns
`include "ppgc_defines.svh"
module ppgc_top
  import ppgc_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // pins
  input  wire logic        TRIGGER_IN,
  output logic             PULSE_OUT,
  output logic             IRQ
);
  ppgc_state_t s_r;
  ppgc_state_t s_nxt;

  // every check below runs on the bus clock and sleeps during reset
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  // divider ratio minus one, from the 4-bit clock select
  function automatic logic [10:0] div_limit(input logic [3:0] cks);
    case (cks)
      4'h0: div_limit = 11'h000;
      4'h1: div_limit = 11'h003;
      4'h2: div_limit = 11'h00F;
      4'h3: div_limit = 11'h07F;
      4'h4: div_limit = 11'h0FF;
      4'h8: div_limit = 11'h1FF;
      4'h9: div_limit = 11'h3FF;
      4'hA: div_limit = 11'h7FF;
      default: div_limit = 11'h000;
    endcase
  endfunction

  logic        acc;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        ext_edge;
  logic        sw_trg;
  logic        stop_wr;
  logic        start;
  logic        udf;
  logic        is_ppg;
  logic [3:0]  cks;
  logic [15:0] wd;

  // ==========================================================
  // bus decode
  always_comb begin
    acc    = PSEL && PENABLE && s_r.pready;
    wr     = acc && PWRITE;
    rd     = PSEL && !PENABLE && !PWRITE;
    wd     = PWDATA[15:0];
    is_ppg = s_r.ctrl.function_select == `PPGC_FMD_PPG;
    cks    = {s_r.ctrl.count_clock_select_msb, s_r.ctrl.clk_sel_lo};
    // external clock codes fall back to the peripheral clock here
    tick   = s_r.presc == div_limit(cks);
    ext_edge = (s_r.ctrl.edge_sel[0] && s_r.trg_sync[1] && !s_r.trg_sync[2])
            || (s_r.ctrl.edge_sel[1] && !s_r.trg_sync[1] && s_r.trg_sync[2]);
    // a control write rewrites the enable, so the trigger needs the new one
    stop_wr = wr && PADDR == `PPGC_OFS_CTRL && PSTRB[0]
              && !PWDATA[`PPGC_CT_COUNT_ENABLE];
    sw_trg = wr && PADDR == `PPGC_OFS_CTRL && PSTRB[0]
             && PWDATA[`PPGC_CT_SOFTWARE_TRIGGER]
             && PWDATA[`PPGC_CT_COUNT_ENABLE];
    // an edge or underflow in the cycle of a stop must not rearm the pulse
    start  = is_ppg && (sw_trg
             || (s_r.ctrl.count_enable && !stop_wr && ext_edge));
    udf    = is_ppg && s_r.ctrl.count_enable && s_r.phase != PH_IDLE
             && !stop_wr
             && tick && s_r.counter_value == `PPGC_UNDERFLOW;
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.trg_sync = {s_r.trg_sync[1:0], TRIGGER_IN};
    if (PSEL && !PENABLE) begin
      s_nxt.pready = 1'b1;
    end
    // read data is prepared in the setup cycle
    if (rd) begin
      case (PADDR)
        `PPGC_OFS_CTRL: s_nxt.prdata = {16'h0000, 1'b0, s_r.ctrl.clk_sel_lo,
                          1'b0, 1'b0, s_r.ctrl.edge_sel, 1'b0,
                          s_r.ctrl.function_select, s_r.ctrl.output_polarity,
                          s_r.ctrl.one_shot_select, s_r.ctrl.count_enable,
                          1'b0};
        `PPGC_OFS_STAT: s_nxt.prdata = {16'h0000, 7'h00,
                          s_r.ctrl.count_clock_select_msb, 1'b0,
                          s_r.trigger_irq_enable, 1'b0,
                          s_r.underflow_irq_enable, 1'b0, s_r.trigger_flag,
                          1'b0, s_r.underflow_flag};
        `PPGC_OFS_LOW:   s_nxt.prdata = {16'h0000, s_r.low_width_reload};
        `PPGC_OFS_HIGH:  s_nxt.prdata = {16'h0000, s_r.high_width_reload};
        `PPGC_OFS_COUNT: s_nxt.prdata = {16'h0000, s_r.counter_value};
        default:         s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // count clock prescaler restarts while stopped
    if (!s_r.ctrl.count_enable || tick || start) begin
      s_nxt.presc = 11'h000;
    end else begin
      s_nxt.presc = s_r.presc + 11'h001;
    end
    // register writes
    if (wr) begin
      case (PADDR)
        `PPGC_OFS_CTRL: begin
          if (PSTRB[0]) begin
            s_nxt.ctrl.function_select = PWDATA[`PPGC_CT_FMD_LO +: 3];
            s_nxt.ctrl.output_polarity = PWDATA[`PPGC_CT_POL];
            s_nxt.ctrl.one_shot_select = PWDATA[`PPGC_CT_ONE_SHOT_SELECT];
            s_nxt.ctrl.count_enable    = PWDATA[`PPGC_CT_COUNT_ENABLE];
            if (!PWDATA[`PPGC_CT_COUNT_ENABLE]) begin
              s_nxt.phase = PH_IDLE;
            end
          end
          if (PSTRB[1]) begin
            s_nxt.ctrl.clk_sel_lo = PWDATA[`PPGC_CT_CKS_LO +: 3];
            s_nxt.ctrl.edge_sel   = PWDATA[`PPGC_CT_EGS_LO +: 2];
          end
        end
        `PPGC_OFS_STAT: begin
          if (PSTRB[0]) begin
            s_nxt.trigger_irq_enable   = PWDATA[`PPGC_ST_TRIGGER_IRQ_ENABLE];
            s_nxt.underflow_irq_enable = PWDATA[`PPGC_ST_UNDERFLOW_IRQ_ENABLE];
            if (!PWDATA[`PPGC_ST_TRG]) begin
              s_nxt.trigger_flag = 1'b0;
            end
            if (!PWDATA[`PPGC_ST_UDF]) begin
              s_nxt.underflow_flag = 1'b0;
            end
          end
          if (PSTRB[1]) begin
            s_nxt.ctrl.count_clock_select_msb = PWDATA[`PPGC_CT2_COUNT_CLOCK_SELECT_MSB];
          end
        end
        // byte writes to the widths are not meaningful; need both lanes
        `PPGC_OFS_LOW: begin
          if (PSTRB[1:0] == 2'b11) begin
            s_nxt.low_width_reload = wd;
          end
        end
        `PPGC_OFS_HIGH: begin
          if (PSTRB[1:0] == 2'b11) begin
            s_nxt.high_width_reload = wd;
          end
        end
        default: begin
        end
      endcase
    end
    // counting; a start also restarts a running pulse
    if (start) begin
      s_nxt.counter_value     = s_r.low_width_reload;
      s_nxt.high_width_buffer = s_r.high_width_reload;
      s_nxt.phase             = PH_LOW;
      s_nxt.presc             = 11'h000;
    end else if (udf) begin
      case (s_r.phase)
        PH_LOW: begin
          s_nxt.counter_value = s_r.high_width_buffer;
          s_nxt.phase         = PH_HIGH;
        end
        PH_HIGH: begin
          s_nxt.counter_value     = s_r.low_width_reload;
          s_nxt.high_width_buffer = s_r.high_width_reload;
          s_nxt.phase = s_r.ctrl.one_shot_select ? PH_IDLE : PH_LOW;
        end
        default: s_nxt.phase = PH_IDLE;
      endcase
    end else if (tick && s_r.phase != PH_IDLE && s_r.ctrl.count_enable) begin
      s_nxt.counter_value = s_r.counter_value - 16'h0001;
    end
    // hardware set wins over a software clear
    if (start) begin
      s_nxt.trigger_flag = 1'b1;
    end
    if (udf && s_r.phase == PH_HIGH) begin
      s_nxt.underflow_flag = 1'b1;
    end
    s_nxt.out_lvl = s_nxt.phase == PH_HIGH;
    s_nxt.pin     = s_nxt.out_lvl ^ s_nxt.ctrl.output_polarity;
    s_nxt.irq = (s_nxt.trigger_flag && s_nxt.trigger_irq_enable)
             || (s_nxt.underflow_flag && s_nxt.underflow_irq_enable);
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s_r       <= '0;
      s_r.phase <= PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    PREADY    = s_r.pready;
    PRDATA    = s_r.prdata;
    PSLVERR   = 1'b0;
    PULSE_OUT = s_r.pin;
    IRQ       = s_r.irq;
  end

  // ==========================================================
  // checks
  a_irq_or_flags: assert property (@(posedge CLOCK) disable iff (!NRST)
    IRQ == ((s_r.trigger_flag && s_r.trigger_irq_enable)
         || (s_r.underflow_flag && s_r.underflow_irq_enable)))
    else $error("irq does not match gated flags");

  a_start_sets_flag: assert property (@(posedge CLOCK) disable iff (!NRST)
    start |=> s_r.trigger_flag)
    else $error("trigger flag not set by start");

  a_start_loads_low: assert property (@(posedge CLOCK) disable iff (!NRST)
    start |=> s_r.counter_value == $past(s_r.low_width_reload)
              && s_r.phase == PH_LOW)
    else $error("start did not load low width");

  a_low_end_high: assert property (@(posedge CLOCK) disable iff (!NRST)
    (udf && !start && s_r.phase == PH_LOW) |=>
      s_r.counter_value == $past(s_r.high_width_buffer) && PULSE_OUT
        == !s_r.ctrl.output_polarity)
    else $error("low phase end did not load high buffer");

  a_udf_only_high: assert property (@(posedge CLOCK) disable iff (!NRST)
    (!s_r.underflow_flag && !(udf && s_r.phase == PH_HIGH)) |=>
      !s_r.underflow_flag)
    else $error("underflow flag set outside high phase");

  a_stop_forces_low: assert property (@(posedge CLOCK) disable iff (!NRST)
    (wr && PADDR == `PPGC_OFS_CTRL && PSTRB[0] && !PWDATA[`PPGC_CT_COUNT_ENABLE])
      |=> PULSE_OUT == s_r.ctrl.output_polarity)
    else $error("stop did not force idle level");

  a_trg_clear: assert property (@(posedge CLOCK) disable iff (!NRST)
    (wr && PADDR == `PPGC_OFS_STAT && PSTRB[0] && !PWDATA[`PPGC_ST_TRG]
      && !start) |=> !s_r.trigger_flag)
    else $error("trigger flag not cleared");

  a_software_trigger_reads_0: assert property (@(posedge CLOCK) disable iff (!NRST)
    (PSEL && PENABLE && !PWRITE && PADDR == `PPGC_OFS_CTRL) |-> !PRDATA[0])
    else $error("software trigger bit read as one");

  a_oneshot_stop: assert property (@(posedge CLOCK) disable iff (!NRST)
    (udf && !start && s_r.phase == PH_HIGH && s_r.ctrl.one_shot_select)
      |=> s_r.phase == PH_IDLE)
    else $error("one-shot did not stop");

  a_fsel_gate: assert property (
    (s_r.phase == PH_IDLE && !is_ppg)
      |=> s_r.phase == PH_IDLE)
    else $error("pulse started outside the pulse function");

  a_pol_level: assert property (
    PULSE_OUT
      == ((s_r.phase == PH_HIGH) ^ s_r.ctrl.output_polarity))
    else $error("output level does not follow phase and polarity");

  a_hold_stopped: assert property (
    (!s_r.ctrl.count_enable && !start)
      |=> $stable(s_r.counter_value))
    else $error("counter moved while stopped");

  a_count_down: assert property (
    (tick && s_r.phase != PH_IDLE && s_r.ctrl.count_enable
      && !udf && !start)
      |=> s_r.counter_value == $past(s_r.counter_value) - 16'h0001)
    else $error("counter did not step down");

  a_sw_start: assert property (
    (sw_trg && is_ppg)
      |=> s_r.phase == PH_LOW && s_r.ctrl.count_enable)
    else $error("software trigger did not start");

  a_software_trigger_needs_en: assert property (
    stop_wr |=> s_r.phase == PH_IDLE
      && !s_r.ctrl.count_enable)
    else $error("trigger without enable started the pulse");

  a_trg_gate: assert property (
    (s_r.trigger_flag && s_r.trigger_irq_enable)
      |-> IRQ)
    else $error("enabled trigger flag gave no irq");

  a_udf_gate: assert property (
    (s_r.underflow_flag && s_r.underflow_irq_enable)
      |-> IRQ)
    else $error("enabled underflow flag gave no irq");

  a_ext_start: assert property (
    (ext_edge && s_r.ctrl.count_enable && is_ppg && !stop_wr)
      |=> s_r.trigger_flag && s_r.phase == PH_LOW)
    else $error("input edge did not start");

  a_flag_keep: assert property (
    (s_r.trigger_flag && !(wr && PADDR == `PPGC_OFS_STAT && PSTRB[0]
      && !PWDATA[`PPGC_ST_TRG])) |=> s_r.trigger_flag)
    else $error("trigger flag lost without a clear");

  a_udf_clear: assert property (
    (wr && PADDR == `PPGC_OFS_STAT && PSTRB[0] && !PWDATA[`PPGC_ST_UDF]
      && !(udf && s_r.phase == PH_HIGH)) |=> !s_r.underflow_flag)
    else $error("underflow flag not cleared");

  a_udf_sets: assert property (
    (udf && s_r.phase == PH_HIGH)
      |=> s_r.underflow_flag)
    else $error("high phase underflow did not set flag");

  a_high_end_reload: assert property (
    (udf && !start && s_r.phase == PH_HIGH)
      |=> s_r.counter_value == $past(s_r.low_width_reload)
        && s_r.high_width_buffer == $past(s_r.high_width_reload))
    else $error("high phase end did not reload widths");

  a_ctrl2_reserved: assert property (
    (PSEL && PENABLE && !PWRITE && PADDR == `PPGC_OFS_STAT)
      |-> PRDATA[15:9] == 7'h00)
    else $error("reserved status bits read as one");

  a_width_lanes: assert property (
    (wr && PADDR == `PPGC_OFS_LOW && PSTRB[1:0] != 2'b11)
      |=> $stable(s_r.low_width_reload))
    else $error("partial width write took effect");

  a_start_low_out: assert property (
    start |=> PULSE_OUT == s_r.ctrl.output_polarity
      && s_r.phase == PH_LOW)
    else $error("start did not drive the low level");

  a_irq_quiet: assert property (
    !((s_r.trigger_flag && s_r.trigger_irq_enable)
      || (s_r.underflow_flag && s_r.underflow_irq_enable)) |-> !IRQ)
    else $error("irq without an enabled flag");

  a_idle_hold: assert property (
    (s_r.phase == PH_IDLE && !start)
      |=> s_r.phase == PH_IDLE)
    else $error("pulse left idle without a start");
endmodule

// *** ppgc_pin_model.sv ***
// pin-side partner: drives the trigger pin, measures pulse run lengths
`timescale 1ns/1ns
module ppgc_pin_model (
  // clock
  input  wire logic clock,
  // pins
  input  wire logic pulse_out,
  output logic      trigger_in,
  // run lengths in clock cycles
  output int        hi_len,
  output int        lo_len
);
  logic last_r;
  int   run_r;
  initial begin
    trigger_in = 1'b0;
    last_r     = 1'b0;
    run_r      = 1;
    hi_len     = 0;
    lo_len     = 0;
  end
  // a run counts only once the level changes; idle time joins low runs, or high runs when the polarity is inverted
  always @(posedge clock) begin
    if (pulse_out === last_r) begin
      run_r <= run_r + 1;
    end else begin
      if (last_r) begin
        hi_len <= run_r;
      end else begin
        lo_len <= run_r;
      end
      run_r  <= 1;
      last_r <= pulse_out;
    end
  end
  // the high level held four cycles so the synchroniser sees it
  task automatic fire();
    @(posedge clock);
    trigger_in <= 1'b1;
    repeat (4) @(posedge clock);
    trigger_in <= 1'b0;
  endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the pulse generator control block
`timescale 1ns/1ns
`define CHK(n, e, g) \
  samples_checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); \
  end
module testbench;
  logic        CLOCK   = 1'b0;
  logic        NRST    = 1'b0;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [11:0] PADDR   = 12'h000;
  logic [31:0] PWDATA  = 32'h0;
  logic [3:0]  PSTRB   = 4'hF;
  logic        PREADY, PSLVERR, PULSE_OUT, IRQ, TRIGGER_IN;
  logic [31:0] PRDATA, rdat;
  int          hi_len, lo_len;
  int          cyc             = 0;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  always #5 CLOCK = ~CLOCK;
  ppgc_top i_ppgc_top (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .TRIGGER_IN(TRIGGER_IN), .PULSE_OUT(PULSE_OUT), .IRQ(IRQ));
  ppgc_pin_model i_ppgc_pin_model (.clock(CLOCK), .pulse_out(PULSE_OUT),
    .trigger_in(TRIGGER_IN), .hi_len(hi_len), .lo_len(lo_len));
  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    PSTRB   <= s;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rdat = PRDATA;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string n);
    apb(1'b0, a, 32'h0, 4'hF);
    `CHK(n, e, rdat)
    `CHK("no slave error", 1'b0, PSLVERR)
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // the whole run needs well under two thousand cycles
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (6) @(posedge CLOCK);
    NRST <= 1'b1;
    `CHK("pulse idle", 1'b0, PULSE_OUT)
    `CHK("irq idle", 1'b0, IRQ)
    rd(12'h000, 32'h0, "ctrl reset");
    rd(12'h004, 32'h0, "stat reset");
    rd(12'h010, 32'h0, "count reset");
    rd(12'h014, 32'h0, "unmapped");
    for (int f = 0; f < 5; f++) begin
      wr(12'h000, 32'(f << 4));
      rd(12'h000, 32'(f << 4), "function");
    end
    wr(12'h000, 32'h20);
    wr(12'h008, 32'h2);
    wr(12'h00C, 32'h3);
    apb(1'b1, 12'h008, 32'h55, 4'h1);
    rd(12'h008, 32'h2, "low width");
    wr(12'h000, 32'h23);
    rd(12'h004, 32'h4, "trig flag");
    rd(12'h000, 32'h22, "sw trigger");
    repeat (40) @(posedge CLOCK);
    `CHK("low len", 3, lo_len)
    `CHK("high len", 4, hi_len)
    rd(12'h004, 32'h5, "udf flag");
    wr(12'h00C, 32'h5);
    repeat (40) @(posedge CLOCK);
    `CHK("buffered high", 6, hi_len)
    `CHK("reloaded low", 3, lo_len)
    wr(12'h000, 32'h20);
    repeat (3) @(posedge CLOCK);
    `CHK("stopped out", 1'b0, PULSE_OUT)
    wr(12'h004, 32'h5);
    rd(12'h004, 32'h5, "flags kept");
    wr(12'h004, 32'h0);
    rd(12'h004, 32'h0, "flags clear");
    wr(12'h004, 32'h40);
    wr(12'h000, 32'h23);
    repeat (2) @(posedge CLOCK);
    `CHK("irq trigger", 1'b1, IRQ)
    wr(12'h004, 32'h10);
    repeat (20) @(posedge CLOCK);
    `CHK("irq udf", 1'b1, IRQ)
    wr(12'h004, 32'h41);
    repeat (2) @(posedge CLOCK);
    `CHK("irq gated", 1'b0, IRQ)
    rd(12'h004, 32'h41, "gated flags");
    wr(12'h000, 32'h20);
    wr(12'h004, 32'hFFFF_FF00);
    rd(12'h004, 32'h100, "ctrl two");
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h28);
    repeat (3) @(posedge CLOCK);
    `CHK("inverted idle", 1'b1, PULSE_OUT)
    wr(12'h00C, 32'hFF);
    wr(12'h000, 32'h122);
    i_ppgc_pin_model.fire();
    repeat (3) @(posedge CLOCK);
    rd(12'h004, 32'h4, "edge trigger");
    wr(12'h000, 32'h20);
    wr(12'h008, 32'h0);
    wr(12'h00C, 32'h1);
    wr(12'h000, 32'h23);
    repeat (20) @(posedge CLOCK);
    `CHK("zero low", 1, lo_len)
    `CHK("one high", 2, hi_len)
    wr(12'h000, 32'h20);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h27);
    repeat (30) @(posedge CLOCK);
    rd(12'h004, 32'h5, "one shot");
    wr(12'h004, 32'h0);
    repeat (20) @(posedge CLOCK);
    rd(12'h004, 32'h0, "one shot idle");
    `CHK("one shot out", 1'b0, PULSE_OUT)
    tally_and_finish();
  end
endmodule
